// file: pkg/rsf_cfg.svh
// constants of the sample, fourier and differential scheduling core
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH
`define RSF_NCH 4
`define RSF_SW 16
`define RSF_NDIN 8
`define RSF_SPC 24
`define RSF_FPC 8
`define RSF_HIST 48
`define RSF_AUTO_SETS 3'h6
`define RSF_HALF_CYCLE_SMP (`RSF_SPC / 2)
`define RSF_DB_COUNT 4'(`RSF_HALF_CYCLE_SMP)
`define RSF_CLK_HZ 250000000
`define RSF_NOM_HZ 50
`define RSF_TRK_STEP 20'h00010
`define RSF_SH_SET 4'h0
`define RSF_SH_CMD 4'h4
`define RSF_SH_DRE 4'h8
`define RSF_SH_DIM 4'h9
`define RSF_SH_OUT 4'hc
`endif

// file: pkg/rsf_pkg.sv
// types of the sample, fourier and differential scheduling core
`include "rsf_cfg.svh"
package rsf_pkg;
   typedef logic signed [`RSF_NCH-1:0][`RSF_SW-1:0] rsf_set_type;
   typedef struct packed {
      logic signed [23:0] re;
      logic signed [23:0] im;
   } rsf_phasor_type;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } rsf_state_type;
endpackage

// file: design/rsf_core.sv
// sample acquisition, fourier and differential scheduling core
`timescale 1ns/1ps
`include "rsf_cfg.svh"
module rsf_core
   import rsf_pkg::*;
#(
   parameter logic [19:0] SMP_PERIOD = 20'(`RSF_CLK_HZ / (`RSF_NOM_HZ * `RSF_SPC)),
   parameter logic [19:0] FIX_PERIOD = 20'(`RSF_CLK_HZ / (`RSF_NOM_HZ * `RSF_FPC))
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // sample sets from the input module
   input wire logic smpValid,
   input wire rsf_set_type smpSet,
   output logic smpReady,
   output logic sampleStrobe,
   output logic [19:0] freqPeriod,
   // digital inputs
   input wire logic [`RSF_NDIN-1:0] dinRaw,
   input wire logic [`RSF_NDIN-1:0] dbEnable,
   output logic [`RSF_NDIN-1:0] dinState,
   // protection trigger and fourier results
   input wire logic coTrigger,
   output logic fundValid,
   output rsf_phasor_type [`RSF_NCH-1:0] fund,
   // raw forwarding
   output logic rawValid,
   output rsf_set_type rawSet,
   // differential measurement and link
   output logic diffValid,
   output rsf_phasor_type diff,
   output logic msgValid,
   input wire logic linkIntertrip,
   input wire logic linkReconfig,
   output logic intertripOut,
   output logic reconfigOut,
   output logic txIntertrip,
   // shared memory port of the main processor
   input wire logic mainReq,
   input wire logic mainWe,
   input wire logic [3:0] mainAddr,
   input wire logic [15:0] mainWdata,
   output logic [15:0] mainRdata,
   output logic coPaused
);

   // sine of k*15 degrees, scaled to 2^14
   function automatic logic signed [15:0] rsfSin(input logic [4:0] k);
      logic [4:0] m;
      logic [2:0] q;
      logic signed [15:0] v;
      m = (k >= 5'd12) ? k - 5'd12 : k;
      q = (m > 5'd6) ? 3'(5'd12 - m) : 3'(m);
      unique case (q)
         3'h0: v = 16'sh0000;
         3'h1: v = 16'sh1090;
         3'h2: v = 16'sh2000;
         3'h3: v = 16'sh2d41;
         3'h4: v = 16'sh376d;
         3'h5: v = 16'sh3dd2;
         3'h6: v = 16'sh4000;
         default: v = 16'sh0000;
      endcase
      return (k >= 5'd12) ? -v : v;
   endfunction

   function automatic logic signed [15:0] rsfCos(input logic [4:0] k);
      return rsfSin((k >= 5'd18) ? k - 5'd18 : k + 5'd6);
   endfunction

   // wrap into the 48-entry history
   function automatic logic [5:0] rsfWrap(input logic [6:0] v);
      return (v >= 7'd48) ? 6'(v - 7'd48) : v[5:0];
   endfunction

   // two-entry input buffer
   rsf_set_type fifoMem_q [2];
   logic fifoWp_q, fifoRp_q;
   logic [1:0] fifoCnt_q, fifoCnt_d;
   logic smpReady_q;
   rsf_state_type state_q;
   wire push = smpValid && smpReady_q;
   wire pop = (fifoCnt_q != 2'd0) && (state_q == ST_IDLE); // stalls during a fourier run
   wire rsf_set_type head = fifoMem_q[fifoRp_q];
   assign fifoCnt_d = fifoCnt_q + 2'(push) - 2'(pop);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fifoWp_q <= 1'b0;
         fifoRp_q <= 1'b0;
         fifoCnt_q <= 2'd0;
         smpReady_q <= 1'b0;
      end else begin
         fifoWp_q <= fifoWp_q ^ push;
         fifoRp_q <= fifoRp_q ^ pop;
         fifoCnt_q <= fifoCnt_d;
         smpReady_q <= (fifoCnt_d != 2'd2);
      end
   end

   always_ff @(posedge clock) begin
      if (push) fifoMem_q[fifoWp_q] <= smpSet;
   end

   // two-cycle history store
   rsf_set_type hist_q [`RSF_HIST];
   logic [5:0] histWp_q;
   wire [5:0] oldIdx = rsfWrap({1'b0, histWp_q} + 7'd24);

   always_ff @(posedge clock) begin
      if (pop) hist_q[histWp_q] <= head;
   end

   // frequency tracking by sliding fourier on channel 0
   logic [4:0] trkK_q;
   logic signed [39:0] trkRe_q, trkIm_q;
   logic signed [15:0] prevRe_q, prevIm_q;
   logic [19:0] smpPeriod_q;
   // channel selects lose the sign, so restore it before extending
   wire signed [16:0] trkDelta = 17'(signed'(head[0])) - 17'(signed'(hist_q[oldIdx][0]));
   wire signed [39:0] trkReNext = trkRe_q + 40'(trkDelta * rsfCos(trkK_q));
   wire signed [39:0] trkImNext = trkIm_q - 40'(trkDelta * rsfSin(trkK_q));
   wire signed [15:0] trkReTop = trkReNext[39:24];
   wire signed [15:0] trkImTop = trkImNext[39:24];
   wire signed [31:0] drift = trkImTop * prevRe_q - trkReTop * prevIm_q;
   wire cycleEnd = pop && (trkK_q == 5'd23);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         histWp_q <= 6'd0;
         trkK_q <= 5'd0;
         trkRe_q <= 40'sd0;
         trkIm_q <= 40'sd0;
         prevRe_q <= 16'sd0;
         prevIm_q <= 16'sd0;
         smpPeriod_q <= SMP_PERIOD;
      end else if (pop) begin
         histWp_q <= rsfWrap({1'b0, histWp_q} + 7'd1);
         trkK_q <= cycleEnd ? 5'd0 : trkK_q + 5'd1;
         trkRe_q <= trkReNext;
         trkIm_q <= trkImNext;
         if (cycleEnd) begin
            prevRe_q <= trkReNext[39:24];
            prevIm_q <= trkImNext[39:24];
            // phase advancing means signal faster than 24 per cycle
            if (drift > 32'sd0) smpPeriod_q <= smpPeriod_q - `RSF_TRK_STEP;
            else if (drift < 32'sd0) smpPeriod_q <= smpPeriod_q + `RSF_TRK_STEP;
         end
      end
   end

   // tracked-rate sample strobe to the input module
   logic [19:0] smpCnt_q;
   logic smpStrobe_q;
   wire smpWrap = (smpCnt_q + 20'd1 >= smpPeriod_q);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         smpCnt_q <= 20'd0;
         smpStrobe_q <= 1'b0;
      end else begin
         smpCnt_q <= smpWrap ? 20'd0 : smpCnt_q + 20'd1;
         smpStrobe_q <= smpWrap;
      end
   end

   // digital input filtering, one counter per input
   logic [`RSF_NDIN-1:0] dinLast_q, dinState_q;
   logic [3:0] dbCnt_q [`RSF_NDIN];

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dinLast_q <= '0;
         dinState_q <= '0;
         for (int i = 0; i < `RSF_NDIN; i++) dbCnt_q[i] <= 4'd0;
      end else begin
         for (int i = 0; i < `RSF_NDIN; i++) begin
            if (!dbEnable[i]) begin
               dinState_q[i] <= dinRaw[i];
               dbCnt_q[i] <= 4'd0;
            end else if (smpStrobe_q) begin
               dinLast_q[i] <= dinRaw[i];
               if (dinRaw[i] != dinLast_q[i]) dbCnt_q[i] <= 4'd1;
               else if (dbCnt_q[i] < `RSF_DB_COUNT) dbCnt_q[i] <= dbCnt_q[i] + 4'd1;
               if (dinRaw[i] == dinLast_q[i] && dbCnt_q[i] == `RSF_DB_COUNT - 4'd1)
                  dinState_q[i] <= dinRaw[i];
            end
         end
      end
   end

   // protection trigger scheduling
   logic trigPend_q;
   logic [2:0] autoCnt_q;
   logic [4:0] dftK_q;
   logic [5:0] dftBase_q;
   wire start = (state_q == ST_IDLE) && !pop && (trigPend_q || autoCnt_q >= `RSF_AUTO_SETS);
   wire dftLast = (state_q == ST_RUN) && (dftK_q == 5'd23);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         trigPend_q <= 1'b0;
         autoCnt_q <= 3'd0;
      end else begin
         trigPend_q <= coTrigger || (trigPend_q && !start);
         if (start) autoCnt_q <= 3'd0;
         else if (pop && autoCnt_q < `RSF_AUTO_SETS) autoCnt_q <= autoCnt_q + 3'd1;
         unique case (state_q)
            ST_IDLE: if (start) state_q <= ST_RUN;
            ST_RUN: if (dftLast) state_q <= ST_IDLE;
         endcase
      end
   end

   // one-cycle fourier over all channels
   logic signed [39:0] accRe_q [`RSF_NCH];
   logic signed [39:0] accIm_q [`RSF_NCH];
   logic signed [39:0] accReNext [`RSF_NCH];
   logic signed [39:0] accImNext [`RSF_NCH];
   wire rsf_set_type dftSet = hist_q[rsfWrap({1'b0, dftBase_q} + {2'b00, dftK_q})];
   rsf_phasor_type [`RSF_NCH-1:0] fund_q;
   logic fundValid_q;

   always_comb begin
      for (int c = 0; c < `RSF_NCH; c++) begin
         accReNext[c] = accRe_q[c] + 40'(signed'(dftSet[c]) * rsfCos(dftK_q));
         accImNext[c] = accIm_q[c] - 40'(signed'(dftSet[c]) * rsfSin(dftK_q));
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dftK_q <= 5'd0;
         dftBase_q <= 6'd0;
         fundValid_q <= 1'b0;
         fund_q <= '0;
         for (int c = 0; c < `RSF_NCH; c++) begin
            accRe_q[c] <= 40'sd0;
            accIm_q[c] <= 40'sd0;
         end
      end else begin
         fundValid_q <= dftLast;
         if (start) begin
            dftK_q <= 5'd0;
            dftBase_q <= oldIdx;
            for (int c = 0; c < `RSF_NCH; c++) begin
               accRe_q[c] <= 40'sd0;
               accIm_q[c] <= 40'sd0;
            end
         end else if (state_q == ST_RUN) begin
            dftK_q <= dftK_q + 5'd1;
            for (int c = 0; c < `RSF_NCH; c++) begin
               accRe_q[c] <= accReNext[c];
               accIm_q[c] <= accImNext[c];
               if (dftLast) begin
                  fund_q[c].re <= accReNext[c][37:14];
                  fund_q[c].im <= accImNext[c][37:14];
               end
            end
         end
      end
   end

   // raw sample forwarding
   logic rawValid_q;
   rsf_set_type rawSet_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rawValid_q <= 1'b0;
         rawSet_q <= '0;
      end else begin
         rawValid_q <= pop;
         if (pop) rawSet_q <= head;
      end
   end

   // fixed nominal-rate resampling and sliding 8-point fourier
   logic [19:0] fixCnt_q;
   logic fixPend_q, msgPhase_q, diffValid_q, msgValid_q;
   logic signed [15:0] lastCh0_q;
   logic signed [15:0] ring_q [`RSF_FPC];
   logic [2:0] fk_q;
   logic signed [39:0] dRe_q, dIm_q;
   wire fixTick = (fixCnt_q + 20'd1 >= FIX_PERIOD);
   wire fixGo = fixPend_q && !mainReq; // halted while main accesses shared memory
   wire [4:0] fCoef = 5'({2'b00, fk_q} * 5'd3);
   wire signed [16:0] fDelta = 17'(lastCh0_q) - 17'(ring_q[fk_q]);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fixCnt_q <= 20'd0;
         fixPend_q <= 1'b0;
         lastCh0_q <= 16'sd0;
         fk_q <= 3'd0;
         dRe_q <= 40'sd0;
         dIm_q <= 40'sd0;
         msgPhase_q <= 1'b0;
         diffValid_q <= 1'b0;
         msgValid_q <= 1'b0;
         for (int j = 0; j < `RSF_FPC; j++) ring_q[j] <= 16'sd0;
      end else begin
         fixCnt_q <= fixTick ? 20'd0 : fixCnt_q + 20'd1;
         fixPend_q <= fixTick || (fixPend_q && !fixGo);
         if (pop) lastCh0_q <= head[0];
         diffValid_q <= fixGo;
         msgValid_q <= fixGo && msgPhase_q;
         if (fixGo) begin
            ring_q[fk_q] <= lastCh0_q;
            fk_q <= fk_q + 3'd1;
            dRe_q <= dRe_q + 40'(fDelta * rsfCos(fCoef));
            dIm_q <= dIm_q - 40'(fDelta * rsfSin(fCoef));
            msgPhase_q <= !msgPhase_q;
         end
      end
   end

   // shared memory and link command handling
   logic [15:0] shMem_q [16];
   logic [15:0] mainRdata_q;
   logic coPaused_q, itPend_q, rcPend_q, intertripOut_q, reconfigOut_q, txIt_q;
   wire coFree = !mainReq;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int a = 0; a < 16; a++) shMem_q[a] <= 16'h0000;
         mainRdata_q <= 16'h0000;
         coPaused_q <= 1'b0;
         itPend_q <= 1'b0;
         rcPend_q <= 1'b0;
         intertripOut_q <= 1'b0;
         reconfigOut_q <= 1'b0;
         txIt_q <= 1'b0;
      end else begin
         coPaused_q <= mainReq;
         intertripOut_q <= linkIntertrip;
         reconfigOut_q <= linkReconfig;
         itPend_q <= linkIntertrip || (itPend_q && !coFree);
         rcPend_q <= linkReconfig || (rcPend_q && !coFree);
         txIt_q <= shMem_q[`RSF_SH_CMD][0];
         if (mainReq) begin
            mainRdata_q <= shMem_q[mainAddr];
            if (mainWe) shMem_q[mainAddr] <= mainWdata;
         end else begin
            // latest measurement lands as soon as main lets go, none is lost
            shMem_q[`RSF_SH_DRE] <= dRe_q[37:22];
            shMem_q[`RSF_SH_DIM] <= dIm_q[37:22];
            shMem_q[`RSF_SH_OUT][0] <= shMem_q[`RSF_SH_OUT][0] | itPend_q | linkIntertrip;
            shMem_q[`RSF_SH_OUT][1] <= shMem_q[`RSF_SH_OUT][1] | rcPend_q | linkReconfig;
         end
      end
   end

   // outputs
   assign smpReady = smpReady_q;
   assign sampleStrobe = smpStrobe_q;
   assign freqPeriod = smpPeriod_q;
   assign dinState = dinState_q;
   assign fundValid = fundValid_q;
   assign fund = fund_q;
   assign rawValid = rawValid_q;
   assign rawSet = rawSet_q;
   assign diffValid = diffValid_q;
   assign diff = '{re: dRe_q[37:14], im: dIm_q[37:14]};
   assign msgValid = msgValid_q;
   assign intertripOut = intertripOut_q;
   assign reconfigOut = reconfigOut_q;
   assign txIntertrip = txIt_q;
   assign mainRdata = mainRdata_q;
   assign coPaused = coPaused_q;

endmodule // rsf_core

// file: tb/rsf_core_props.sv
// port checks of the scheduling core
`timescale 1ns/1ps
module rsf_core_props
   import rsf_pkg::*;
#(
   parameter logic [19:0] SMP_PERIOD = 20'h00032,
   parameter logic [19:0] FIX_PERIOD = 20'h00096
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // sample path and trigger
   input wire logic smpValid,
   input wire logic smpReady,
   input wire logic [19:0] freqPeriod,
   input wire logic coTrigger,
   input wire logic fundValid,
   input wire logic rawValid,
   input wire logic diffValid,
   input wire logic msgValid,
   // link and shared memory
   input wire logic linkIntertrip,
   input wire logic intertripOut,
   input wire logic txIntertrip,
   input wire logic mainReq,
   input wire logic mainWe,
   input wire logic [3:0] mainAddr,
   input wire logic [15:0] mainWdata,
   input wire logic coPaused
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   chk_rst_quiet: assert property ($fell(sys_rst) |-> freqPeriod == SMP_PERIOD
      && !fundValid && !rawValid) else $error("outputs wrong after reset");
   chk_ready_up: assert property ($fell(sys_rst) |=> smpReady)
      else $error("ready not raised after reset");
   chk_take_raw: assert property (smpValid && smpReady |-> ##[2:60] rawValid)
      else $error("taken set not forwarded");
   chk_trig_fund: assert property ($rose(coTrigger) |-> ##[2:90] fundValid)
      else $error("trigger gave no fourier result");
   chk_fund_gap: assert property (fundValid |=> !fundValid [*8])
      else $error("fourier results too close");
   chk_diff_gap: assert property (diffValid |=> !diffValid [*8])
      else $error("fixed rate results too close");
   chk_msg_diff: assert property (msgValid |-> diffValid)
      else $error("message without measurement");
   chk_pause_on: assert property (mainReq [*2] |-> coPaused)
      else $error("not paused during access");
   chk_trip_pass: assert property (linkIntertrip |=> intertripOut)
      else $error("intertrip not passed");
   chk_tx_cmd: assert property (mainReq && mainWe && mainAddr == 4'h4 |=> ##1
      txIntertrip == $past(mainWdata[0], 2)) else $error("send command lost");
endmodule // rsf_core_props

bind rsf_core rsf_core_props #(.SMP_PERIOD(SMP_PERIOD), .FIX_PERIOD(FIX_PERIOD))
   u_rsf_core_props (.clock, .sys_rst, .smpValid, .smpReady, .freqPeriod, .coTrigger,
   .fundValid, .rawValid, .diffValid, .msgValid, .linkIntertrip, .intertripOut,
   .txIntertrip, .mainReq, .mainWe, .mainAddr, .mainWdata, .coPaused);

// file: tb/rsf_src_model.sv
// input module and co-processor trigger model
`timescale 1ns/1ps
module rsf_src_model
   import rsf_pkg::*;
#(
   parameter int TRIG_GAP = 300
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // bench controls
   input wire logic srcEn,
   input wire logic slow,
   input wire logic trigEn,
   input wire logic [15:0] mask,
   // sample handshake and trigger
   input wire logic smpReady,
   output logic smpValid,
   output rsf_set_type smpSet,
   output logic coTrigger
);
   logic [15:0] sentCnt;
   logic [3:0] gapCnt;
   int trigCnt;
   // offer a set, hold it until taken, pause in slow mode
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         smpValid <= 1'b0;
         smpSet <= '0;
         sentCnt <= 16'h0000;
         gapCnt <= 4'h0;
      end else if (smpValid && smpReady) begin
         smpValid <= 1'b0;
         smpSet <= ~smpSet; // no stale set once released
         sentCnt <= sentCnt + 16'h0001;
         gapCnt <= slow ? 4'h7 : 4'h0;
      end else if (gapCnt != 4'h0) begin
         gapCnt <= gapCnt - 4'h1;
      end else if (srcEn && !smpValid) begin
         smpValid <= 1'b1;
         smpSet <= {4{sentCnt & mask}};
      end
   end
   // four retriggers per power cycle
   always_ff @(posedge clock) begin
      if (sys_rst || !trigEn) begin
         trigCnt <= 0;
         coTrigger <= 1'b0;
      end else begin
         trigCnt <= (trigCnt == TRIG_GAP - 1) ? 0 : trigCnt + 1;
         coTrigger <= (trigCnt == TRIG_GAP - 1);
      end
   end
endmodule // rsf_src_model

// file: tb/rsf_core_tb.sv
// self-checking bench of the scheduling core
`timescale 1ns/1ps
module rsf_core_tb
   import rsf_pkg::*;
   ;
   logic clock, sys_rst, srcEn, slow, trigEn, smpValid, smpReady, sampleStrobe, coTrigger;
   logic fundValid, rawValid, diffValid, msgValid, linkIntertrip, linkReconfig, intertripOut;
   logic reconfigOut, txIntertrip, mainReq, mainWe, coPaused;
   rsf_set_type smpSet, rawSet;
   rsf_phasor_type [3:0] fund;
   rsf_phasor_type diff;
   logic [19:0] freqPeriod;
   logic [7:0] dinRaw, dbEnable, dinState;
   logic [3:0] mainAddr;
   logic [15:0] mainWdata, mainRdata, mask, rawIdx;
   int mismatches, total_checks;
   // design and source model
   rsf_core #(.SMP_PERIOD(20'h00032), .FIX_PERIOD(20'h00096)) u_rsf_core (.clock, .sys_rst,
      .smpValid, .smpSet, .smpReady, .sampleStrobe, .freqPeriod, .dinRaw, .dbEnable,
      .dinState, .coTrigger, .fundValid, .fund, .rawValid, .rawSet, .diffValid, .diff,
      .msgValid, .linkIntertrip, .linkReconfig, .intertripOut, .reconfigOut, .txIntertrip,
      .mainReq, .mainWe, .mainAddr, .mainWdata, .mainRdata, .coPaused);
   rsf_src_model u_rsf_src_model (.clock, .sys_rst, .srcEn, .slow, .trigEn, .mask,
      .smpReady, .smpValid, .smpSet, .coTrigger);
   task automatic check(input logic [191:0] got, input logic [191:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // forwarded sets must arrive whole and in order
   always @(posedge clock) begin
      if (!sys_rst && rawValid) begin
         check(rawSet, {4{rawIdx & mask}});
         rawIdx <= rawIdx + 16'h0001;
      end
   end
   task automatic t_idle();
      int n;
      n = 0;
      repeat (200) @(negedge clock) n += fundValid;
      check(n, 0);
      check(freqPeriod, 20'h00032);
   endtask
   task automatic t_auto();
      int n;
      n = 0;
      @(posedge clock);
      srcEn <= 1'b1;
      while (fundValid !== 1'b1 && n < 2000) @(negedge clock) n++;
      check(fundValid, 1'b1);
      check(rawIdx >= 16'h0006, 1'b1);
      @(posedge clock);
      srcEn <= 1'b0;
      repeat (60) @(posedge clock);
   endtask
   // older cycle holds the end of a ramp, newest cycle is all zero: only the newest window gives zero
   task automatic t_window();
      int n;
      logic [15:0] r0;
      n = 0;
      r0 = rawIdx + 16'h0018;
      mask <= 16'hffff;
      srcEn <= 1'b1;
      while (rawIdx < r0 && n < 3000) @(negedge clock) n++;
      check(rawIdx >= r0, 1'b1);
      @(posedge clock);
      srcEn <= 1'b0;
      repeat (60) @(posedge clock);
      n = 0;
      r0 = rawIdx + 16'h0024;
      mask <= 16'h0000;
      srcEn <= 1'b1;
      while (rawIdx < r0 && n < 3000) @(negedge clock) n++;
      check(rawIdx >= r0, 1'b1);
      @(posedge clock);
      srcEn <= 1'b0;
      trigEn <= 1'b1;
      n = 0;
      while (fundValid !== 1'b1 && n < 1000) @(negedge clock) n++;
      check(fundValid, 1'b1);
      check(fund, '0);
      @(posedge clock);
      trigEn <= 1'b0;
      repeat (60) @(posedge clock);
   endtask
   task automatic t_buffer();
      int n;
      n = 0;
      mask <= 16'hffff;
      srcEn <= 1'b1;
      trigEn <= 1'b1;
      repeat (600) @(negedge clock) n += (smpValid && !smpReady);
      check(n > 0, 1'b1);
      @(posedge clock);
      slow <= 1'b1;
      repeat (300) @(posedge clock);
      srcEn <= 1'b0;
      trigEn <= 1'b0;
      repeat (60) @(posedge clock);
   endtask
   task automatic t_debounce();
      dbEnable <= 8'h01;
      dinRaw <= 8'h03;
      repeat (3) @(posedge sampleStrobe);
      @(negedge clock);
      check(dinState, 8'h02);
      repeat (8) @(posedge sampleStrobe);
      @(negedge clock);
      check(dinState, 8'h02);
      repeat (2) @(posedge sampleStrobe);
      @(negedge clock);
      check(dinState, 8'h03);
   endtask
   task automatic mem_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      mainReq <= 1'b1;
      mainWe <= 1'b1;
      mainAddr <= a;
      mainWdata <= d;
      @(posedge clock);
      mainReq <= 1'b0;
      mainWe <= 1'b0;
   endtask
   task automatic mem_rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clock);
      mainReq <= 1'b1;
      mainAddr <= a;
      @(posedge clock);
      mainReq <= 1'b0;
      @(negedge clock);
      check(mainRdata, e);
   endtask
   task automatic t_shared();
      mem_wr(4'h0, 16'h5a3c);
      mem_rd(4'h0, 16'h5a3c);
      mem_wr(4'h4, 16'h0001);
      repeat (2) @(negedge clock);
      check(txIntertrip, 1'b1);
      @(posedge clock);
      mainReq <= 1'b1;
      linkReconfig <= 1'b1;
      @(posedge clock);
      linkReconfig <= 1'b0;
      repeat (3) @(negedge clock);
      check({coPaused, reconfigOut}, 2'b10);
      @(posedge clock);
      mainReq <= 1'b0;
      @(posedge clock);
      linkIntertrip <= 1'b1;
      @(posedge clock);
      linkIntertrip <= 1'b0;
      @(negedge clock);
      check(intertripOut, 1'b1);
      mem_rd(4'hc, 16'h0003);
      mem_wr(4'hc, 16'h0000);
      mem_rd(4'hc, 16'h0000);
      mem_wr(4'h4, 16'h0000);
   endtask
   task automatic t_fixed();
      int d, m;
      d = 0;
      m = 0;
      // let a tick held back by the last access pass before counting
      repeat (2) @(posedge clock);
      repeat (600) begin
         @(negedge clock);
         d += diffValid;
         m += msgValid;
      end
      check(d, 4);
      check(m, 2);
   endtask
   // main sequence
   initial begin
      {sys_rst, mismatches, total_checks, rawIdx} = {1'b1, 32'h0, 32'h0, 16'h0000};
      {srcEn, slow, trigEn, linkIntertrip, linkReconfig, mainReq, mainWe} = 7'h00;
      {dinRaw, dbEnable, mainAddr, mainWdata, mask} = {8'h00, 8'h00, 4'h0, 16'h0000, 16'hffff};
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      t_idle();
      t_auto();
      t_window();
      t_buffer();
      t_debounce();
      t_shared();
      t_fixed();
      give_verdict();
   end
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      give_verdict();
   end
endmodule // rsf_core_tb
